// ### core/usb_link_cfg_pkg.sv
package usb_link_cfg_pkg;

  // Register bus geometry
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  CFG_ONE_ADDR    = 8'h00;  // Config word
  localparam logic [7:0]  STATUS_ADDR     = 8'h04;  // Live state word

  // Field positions in the config word
  localparam int          SELF_U1_BIT     = 10;
  localparam int          HOST_U1_BIT     = 9;
  localparam int          LTM_BIT         = 8;
  localparam int          FS_TRIM_LSB     = 4;
  localparam int          TRIM_W          = 3;

  // Field positions in the status word
  localparam int          ST_BUSY_BIT     = 0;
  localparam int          ST_FS_BIT       = 1;
  localparam int          ST_IMG_BIT      = 2;
  localparam int          ST_LIMIT_LSB    = 8;

  // Built-in defaults when no image exists
  localparam logic        SELF_U1_DEF     = 1'b0;
  localparam logic        HOST_U1_DEF     = 1'b1;
  localparam logic        LTM_DEF         = 1'b0;
  localparam logic [2:0]  FS_TRIM_DEF     = 3'h0;

  // Gap timing, counted in 60 MHz PHY clocks
  localparam int          FS_BASE_BITS    = 17;  // Inside 16..18 window
  localparam int          PHY_CLK_PER_BIT = 5;   // 60 MHz over 12 Mb/s
  localparam int          LIMIT_W         = 8;
  localparam logic [7:0]  FS_BASE_CLKS    =
    8'(FS_BASE_BITS * PHY_CLK_PER_BIT);
  localparam logic [7:0]  HS_BASE_CLKS    = 8'h40;  // Plain default

  // Live configuration fields
  typedef struct packed {
    logic        self_u1_entry_allow;
    logic        host_u1_accept;
    logic        latency_tolerance_msg_on;
    logic [2:0]  fullspeed_gap_timeout_trim;
  } link_cfg_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  localparam link_cfg_t CFG_DEFAULT = '{
    self_u1_entry_allow:        SELF_U1_DEF,
    host_u1_accept:             HOST_U1_DEF,
    latency_tolerance_msg_on:   LTM_DEF,
    fullspeed_gap_timeout_trim: FS_TRIM_DEF
  };

endpackage

// ### core/gap_timeout_timer.sv
`timescale 1ns/1ps
module gap_timeout_timer
  import usb_link_cfg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  fullspeed,
  input  wire logic [TRIM_W-1:0]     fs_trim,
  input  wire logic [TRIM_W-1:0]     hs_trim,
  input  wire logic                  phy_tick,
  input  wire logic                  start,
  input  wire logic                  abort,
  output logic      [LIMIT_W-1:0]    limit_r,
  output logic                       busy_r,
  output logic                       expire_r
);

  // Base plus trim, one PHY clock per trim step
  function automatic logic [LIMIT_W-1:0] add_trim(
    input logic [LIMIT_W-1:0] base,
    input logic [TRIM_W-1:0]  trim
  );
    add_trim = base + {{(LIMIT_W-TRIM_W){1'b0}}, trim};
  endfunction

  logic [LIMIT_W-1:0] limit_nxt;  // Mode-selected limit
  logic [LIMIT_W-1:0] count_r;    // PHY clocks elapsed
  logic               hit;        // Limit reached on this tick

  // Off full speed the high-speed trim is used
  assign limit_nxt = fullspeed ? add_trim(FS_BASE_CLKS, fs_trim)
                               : add_trim(HS_BASE_CLKS, hs_trim);
  assign hit = busy_r && phy_tick && (count_r + 8'h01 >= limit_r);

  // Limit is latched so a mid-gap edit cannot shorten a running wait
  always_ff @(posedge clk) begin
    if (!nrst) begin
      limit_r  <= FS_BASE_CLKS;
      count_r  <= 8'h00;
      busy_r   <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= hit && !abort;
      if (abort) begin
        busy_r  <= 1'b0;
      end else if (start) begin
        limit_r <= limit_nxt;
        count_r <= 8'h00;
        busy_r  <= 1'b1;
      end else if (hit) begin
        busy_r  <= 1'b0;
      end else if (busy_r && phy_tick) begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fs_limit_base: assert property (
    start && !abort && fullspeed |=>
      limit_r >= 8'(16 * PHY_CLK_PER_BIT) + {5'h00, $past(fs_trim)} &&
      limit_r <= 8'(18 * PHY_CLK_PER_BIT) + {5'h00, $past(fs_trim)})
    else $error("full-speed gap limit out of range");

  a_hs_trim_used: assert property (
    start && !abort && !fullspeed |=>
      limit_r == HS_BASE_CLKS + {5'h00, $past(hs_trim)})
    else $error("high-speed trim not applied off full speed");

  // A start in the hit cycle, one cycle before the expiry pulse, legally restarts the wait
  a_expire_once: assert property (
    expire_r |=> !expire_r && (!busy_r || $past(start, 2)))
    else $error("timeout pulse longer than one cycle");

endmodule

// ### core/usb_link_power_timeout_cfg.sv
`timescale 1ns/1ps
// Behaviour
// - Self U1 entry needs bit and host feature
// - Bit 9 gates acceptance of host U1
// - The two U1 enables act independently
// - Bit 8 switches latency tolerance messaging
// - Trim 6:4 extends full-speed gap timeout
// - Each trim PHY clock adds 0.2 bits
// - Base full-speed timeout is 16-18 bits
// - Off full speed, use high-speed trim
// - Reset protect shields fields from bus and lite resets
// - Init and LTM default image else 0
// - Host U1 default image else 1
// - Full-speed trim default image else 0
// - Bus or lite reset restores image
module usb_link_power_timeout_cfg
  import usb_link_cfg_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [DATA_W-1:0]       reg_rdata_r,
  input  wire logic                    image_load,
  input  wire logic                    image_present,
  input  wire usb_link_cfg_pkg::link_cfg_t image_cfg,
  input  wire logic                    usb_bus_reset,
  input  wire logic                    lite_soft_reset,
  input  wire logic                    reset_protect,
  input  wire logic                    host_u1_feature_set,
  input  wire logic                    host_u1_request,
  input  wire logic                    fullspeed,
  input  wire logic [TRIM_W-1:0]       highspeed_gap_timeout_trim,
  input  wire logic                    phy_tick,
  input  wire logic                    gap_start,
  input  wire logic                    gap_abort,
  output logic                         self_u1_initiate_ok_r,
  output logic                         host_u1_accept_r,
  output logic                         host_u1_reject_r,
  output logic                         ltm_active_r,
  output logic      [TRIM_W-1:0]       fs_trim_r,
  output logic      [LIMIT_W-1:0]      gap_limit_r,
  output logic                         gap_busy_r,
  output logic                         gap_timeout_r
);

  // Pack the live fields into the config word layout
  function automatic logic [DATA_W-1:0] cfg_word(input link_cfg_t c);
    logic [DATA_W-1:0] w;
    w = 32'h0000_0000;  // Reserved bits stay zero
    w[SELF_U1_BIT] = c.self_u1_entry_allow;
    w[HOST_U1_BIT] = c.host_u1_accept;
    w[LTM_BIT]     = c.latency_tolerance_msg_on;
    w[FS_TRIM_LSB +: TRIM_W] = c.fullspeed_gap_timeout_trim;
    cfg_word = w;
  endfunction

  // Pull the writable fields out of a written word
  function automatic link_cfg_t cfg_fields(input logic [DATA_W-1:0] w);
    link_cfg_t c;
    c.self_u1_entry_allow        = w[SELF_U1_BIT];
    c.host_u1_accept             = w[HOST_U1_BIT];
    c.latency_tolerance_msg_on   = w[LTM_BIT];
    c.fullspeed_gap_timeout_trim = w[FS_TRIM_LSB +: TRIM_W];
    cfg_fields = c;
  endfunction

  reg_req_t          req;           // Bundled bus request
  link_cfg_t         cfg_r;         // Live settings
  link_cfg_t         cfg_nxt;       // Next live settings
  link_cfg_t         shadow_r;      // Image restored on resets
  link_cfg_t         shadow_nxt;    // Next image copy
  logic              img_seen_r;    // An image has been loaded
  logic              hit_cfg;       // Address decodes to config word
  logic              hit_status;    // Address decodes to status word
  logic              cfg_write;     // Software write to config
  logic              link_reset;    // Bus or lite reset this cycle
  logic              restore;       // Reset that may touch the fields
  logic [DATA_W-1:0] status_word;   // Live state view
  logic [DATA_W-1:0] rdata_nxt;     // Read data for next cycle
  logic [LIMIT_W-1:0] limit_w;      // Timer limit from child
  logic              busy_w;        // Timer running from child
  logic              expire_w;      // Timer expiry from child

  assign req = '{addr: reg_addr, wdata: reg_wdata,
                 wr: reg_wr, rd: reg_rd};

  // Address decode
  assign hit_cfg    = (req.addr == CFG_ONE_ADDR);
  assign hit_status = (req.addr == STATUS_ADDR);
  assign cfg_write  = req.wr && hit_cfg;

  // Either link reset, unless protection holds the fields
  assign link_reset = usb_bus_reset || lite_soft_reset;
  assign restore    = link_reset && !reset_protect;

  // No image present leaves the built-in defaults
  assign shadow_nxt = image_present ? image_cfg
                                    : CFG_DEFAULT;

  // Priority: image load, then reset restore, then software
  assign cfg_nxt = image_load ? shadow_nxt
                 : restore    ? shadow_r
                 : cfg_write  ? cfg_fields(req.wdata)
                 : cfg_r;

  // Status word: timer state, speed, image flag and limit
  assign status_word = {16'h0000, limit_w, 5'h00, img_seen_r,
                        fullspeed, busy_w};

  // Unmapped addresses read as zero
  assign rdata_nxt = !req.rd   ? 32'h0000_0000
                   : hit_cfg   ? cfg_word(cfg_r)
                   : hit_status ? status_word
                   : 32'h0000_0000;

  // Shadow image and live settings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shadow_r   <= CFG_DEFAULT;
      cfg_r      <= CFG_DEFAULT;
      img_seen_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      if (image_load) begin
        shadow_r   <= shadow_nxt;
        img_seen_r <= image_present;
      end
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // Link power decisions; each enable feeds only its own path
  always_ff @(posedge clk) begin
    if (!nrst) begin
      self_u1_initiate_ok_r <= 1'b0;
      host_u1_accept_r      <= 1'b0;
      host_u1_reject_r      <= 1'b0;
      ltm_active_r          <= 1'b0;
      fs_trim_r             <= FS_TRIM_DEF;
    end else begin
      // Own U1 entry only with both local and host permission
      self_u1_initiate_ok_r <= cfg_r.self_u1_entry_allow
                               && host_u1_feature_set;
      // Host request answered from bit 9 alone
      host_u1_accept_r <= host_u1_request
                          && cfg_r.host_u1_accept;
      host_u1_reject_r <= host_u1_request
                          && !cfg_r.host_u1_accept;
      ltm_active_r     <= cfg_r.latency_tolerance_msg_on;
      fs_trim_r        <= cfg_r.fullspeed_gap_timeout_trim;
    end
  end

  // Gap timer; limit frozen at start of each wait
  gap_timeout_timer u_gap (
    .clk      (clk),
    .nrst     (nrst),
    .fullspeed(fullspeed),
    .fs_trim  (cfg_r.fullspeed_gap_timeout_trim),
    .hs_trim  (highspeed_gap_timeout_trim),
    .phy_tick (phy_tick),
    .start    (gap_start),
    .abort    (gap_abort),
    .limit_r  (limit_w),
    .busy_r   (busy_w),
    .expire_r (expire_w)
  );

  // Child outputs are flops; plain wires keep ports flop-driven
  assign gap_limit_r   = limit_w;
  assign gap_busy_r    = busy_w;
  assign gap_timeout_r = expire_w;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_self_u1_gate: assert property (
    self_u1_initiate_ok_r |->
      $past(cfg_r.self_u1_entry_allow) && $past(host_u1_feature_set))
    else $error("self U1 allowed without both permissions");

  a_host_u1_answer: assert property (
    host_u1_request |=>
      (host_u1_accept_r == $past(cfg_r.host_u1_accept)) &&
      (host_u1_reject_r != $past(cfg_r.host_u1_accept)))
    else $error("host U1 request answered against bit 9");

  a_u1_independent: assert property (
    host_u1_request && cfg_r.host_u1_accept &&
    !cfg_r.self_u1_entry_allow |=> host_u1_accept_r)
    else $error("host U1 acceptance gated by self enable");

  a_ltm_follows: assert property (
    cfg_write && !image_load && !restore |=> ##1
      ltm_active_r == $past(req.wdata[LTM_BIT], 2))
    else $error("latency messaging does not follow bit 8");

  a_protect_holds: assert property (
    link_reset && reset_protect && !image_load && !cfg_write
      |=> $stable(cfg_r))
    else $error("protected fields disturbed by reset");

  a_restore_image: assert property (
    restore && !image_load |=> cfg_r == $past(shadow_r))
    else $error("link reset did not restore the image");

  a_default_empty: assert property (
    image_load && !image_present |=>
      cfg_r.host_u1_accept && !cfg_r.self_u1_entry_allow &&
      !cfg_r.latency_tolerance_msg_on &&
      cfg_r.fullspeed_gap_timeout_trim == FS_TRIM_DEF)
    else $error("empty image did not give built-in defaults");

  a_reserved_zero: assert property (
    req.rd && hit_cfg |=>
      reg_rdata_r[7] == 1'b0 && reg_rdata_r[3:0] == 4'h0 &&
      reg_rdata_r[31:11] == 21'h000000)
    else $error("reserved config bits read nonzero");

  a_read_one_cycle: assert property (
    !req.rd |=> reg_rdata_r == 32'h0000_0000)
    else $error("read data present without a read");

  a_trim_readback: assert property (
    cfg_write && !image_load && !restore ##1 req.rd && hit_cfg
      |=> reg_rdata_r[FS_TRIM_LSB +: TRIM_W]
          == $past(req.wdata[FS_TRIM_LSB +: TRIM_W], 2))
    else $error("written trim not read back");

endmodule

// ### test/usb_host_model.sv
`timescale 1ns/1ps
// Host side of the link: U1 feature, U1 requests and bus reset
module usb_host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ask_u1,
  input  wire logic feat_u1,
  input  wire logic bus_rst,
  output logic      host_u1_request,
  output logic      host_u1_feature_set,
  output logic      usb_bus_reset
);
  // Requests stay quiet while the device is held in reset
  assign host_u1_request     = ask_u1 & nrst;
  // Feature level as set by SET_FEATURE(U1 Enable)
  assign host_u1_feature_set = feat_u1;
  // Bus reset level, one cycle per restore
  assign usb_bus_reset       = bus_rst;
endmodule

// ### test/usb_link_power_timeout_cfg_bench.sv
`timescale 1ns/1ps
module usb_link_power_timeout_cfg_bench;
  import usb_link_cfg_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, image_load, image_present, lite_soft_reset;
  logic reset_protect, fullspeed, phy_tick, gap_start, gap_abort;
  logic ask, feat, brst, req, fset, ubr, self_ok, acc, rej, ltm, gbusy, gto;
  logic [7:0]  reg_addr, glim;
  logic [31:0] reg_wdata, rdata, d;
  logic [2:0]  hs_trim, fst;
  link_cfg_t   image_cfg;
  int errors = 0;
  int comparisons = 0;
  // Rows: value written, value read back
  logic [31:0] rows [6][2] = '{'{32'h700, 32'h700}, '{32'hFFFFFFFF, 32'h770},
    '{32'h400, 32'h400}, '{32'h100, 32'h100}, '{32'h8C, 32'h0},
    '{32'h230, 32'h230}};

  usb_host_model usb_host_model_i (.clk(clk), .nrst(nrst), .ask_u1(ask),
    .feat_u1(feat), .bus_rst(brst), .host_u1_request(req),
    .host_u1_feature_set(fset), .usb_bus_reset(ubr));

  usb_link_power_timeout_cfg usb_link_power_timeout_cfg_i (.clk(clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(rdata), .image_load(image_load),
    .image_present(image_present), .image_cfg(image_cfg),
    .usb_bus_reset(ubr), .lite_soft_reset(lite_soft_reset),
    .reset_protect(reset_protect), .host_u1_feature_set(fset),
    .host_u1_request(req), .fullspeed(fullspeed),
    .highspeed_gap_timeout_trim(hs_trim), .phy_tick(phy_tick),
    .gap_start(gap_start), .gap_abort(gap_abort),
    .self_u1_initiate_ok_r(self_ok), .host_u1_accept_r(acc),
    .host_u1_reject_r(rej), .ltm_active_r(ltm), .fs_trim_r(fst),
    .gap_limit_r(glim), .gap_busy_r(gbusy), .gap_timeout_r(gto));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One comparison, counted
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Host U1 request; answer lands one cycle later
  task automatic u1_req(input logic exp);
    @(posedge clk);
    ask <= 1'b1;
    @(posedge clk);
    ask <= 1'b0;
    #1 check("u1 accept", acc, exp);
    check("u1 reject", rej, !exp);
  endtask

  // Gap wait with a tick every cycle; counts ticks until expiry
  task automatic gap_run(input logic [7:0] lim);
    int n;
    n = 0;
    @(posedge clk);
    gap_start <= 1'b1;
    @(posedge clk);
    gap_start <= 1'b0;
    phy_tick <= 1'b1;
    #1 check("gap limit", glim, lim);
    check("gap busy", gbusy, 1'b1);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      n++;
      #1;
      if (gto === 1'b1) break;
    end
    check("gap ticks", n, lim);
    check("busy after", gbusy, 1'b0);
    @(posedge clk);
    phy_tick <= 1'b0;
    #1 check("timeout pulse", gto, 1'b0);
  endtask

  // Reset, table rows, then awkward cases
  initial begin
    {reg_wr, reg_rd, image_load, image_present, lite_soft_reset} = '0;
    {reset_protect, phy_tick, gap_start, gap_abort, ask, feat, brst} = '0;
    {nrst, fullspeed, reg_addr, reg_wdata, hs_trim, image_cfg} = '0;
    repeat (12) @(posedge clk);
    #1 check("reset out", {self_ok, acc, rej, ltm, fst, gto}, 0);
    check("reset limit", glim, 8'h55);
    @(posedge clk);
    nrst <= 1'b1;
    rd(CFG_ONE_ADDR, d);
    check("cfg default", d, 32'h200);
    foreach (rows[i]) begin
      wr(CFG_ONE_ADDR, rows[i][0]);
      rd(CFG_ONE_ADDR, d);
      check("cfg read", d, rows[i][1]);
      check("ltm", ltm, rows[i][1][8]);
      check("fs trim", fst, rows[i][1][6:4]);
      @(posedge clk);
      feat <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check("self u1", self_ok, rows[i][1][10]);
      @(posedge clk);
      feat <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("self u1 nofeat", self_ok, 1'b0);
      u1_req(rows[i][1][9]);
    end
    // Trim 3 at full speed, then high-speed trim 5 off full speed
    wr(CFG_ONE_ADDR, 32'h30);
    fullspeed <= 1'b1;
    gap_run(8'd88);
    rd(STATUS_ADDR, d);
    check("status fs", d & 32'h2, 32'h2);
    fullspeed <= 1'b0;
    hs_trim <= 3'h5;
    gap_run(8'd69);
    // Abort in mid-wait: no expiry follows
    @(posedge clk);
    gap_start <= 1'b1;
    phy_tick <= 1'b1;
    @(posedge clk);
    gap_start <= 1'b0;
    gap_abort <= 1'b1;
    @(posedge clk);
    gap_abort <= 1'b0;
    d = 0;
    repeat (90) begin
      @(posedge clk);
      #1 d = d | gto;
    end
    check("abort", {gbusy, d[0]}, 0);
    phy_tick <= 1'b0;
    // Link resets restore defaults, then the loaded image
    wr(CFG_ONE_ADDR, 32'h0);
    @(posedge clk) brst <= 1'b1;
    @(posedge clk) brst <= 1'b0;
    rd(CFG_ONE_ADDR, d);
    check("bus rst default", d, 32'h200);
    @(posedge clk);
    image_load <= 1'b1;
    image_present <= 1'b1;
    image_cfg <= '{1'b1, 1'b0, 1'b1, 3'h5};
    @(posedge clk) image_load <= 1'b0;
    rd(CFG_ONE_ADDR, d);
    check("image load", d, 32'h550);
    // Status: limit 69 from last wait, image seen, idle, not full speed
    rd(STATUS_ADDR, d);
    check("status word", d, 32'h0000_4504);
    wr(CFG_ONE_ADDR, 32'h200);
    @(posedge clk) lite_soft_reset <= 1'b1;
    @(posedge clk) lite_soft_reset <= 1'b0;
    rd(CFG_ONE_ADDR, d);
    check("lite restore", d, 32'h550);
    wr(CFG_ONE_ADDR, 32'h200);
    @(posedge clk) reset_protect <= 1'b1;
    @(posedge clk) brst <= 1'b1;
    @(posedge clk) brst <= 1'b0;
    rd(CFG_ONE_ADDR, d);
    check("protected", d, 32'h200);
    @(posedge clk);
    reset_protect <= 1'b0;
    // Empty image load falls back to built-in defaults
    wr(CFG_ONE_ADDR, 32'h570);
    @(posedge clk);
    image_load <= 1'b1;
    image_present <= 1'b0;
    @(posedge clk) image_load <= 1'b0;
    rd(CFG_ONE_ADDR, d);
    check("empty image", d, 32'h200);
    // Unmapped read and write to the status word
    rd(8'h08, d);
    check("unmapped", d, 32'h0);
    wr(STATUS_ADDR, 32'hFFFFFFFF);
    rd(CFG_ONE_ADDR, d);
    check("status wr", d, 32'h200);
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #80000;
    errors++;
    complete_run();
  end
endmodule
